// ### acir_pkg.sv
// Constants and types for the channel input routing register bank
package acir_pkg;

    // Bank shape
    localparam int unsigned ACIR_CHANNELS = 16;
    localparam int unsigned ACIR_WORD_W   = 16;
    localparam int unsigned ACIR_SEL_W    = 5;
    localparam int unsigned ACIR_SETUP_W  = 3;
    localparam int unsigned ACIR_SLOT_W   = 4;
    localparam int unsigned ACIR_COUNT_W  = 5;

    // Field positions inside a channel word
    localparam int unsigned ACIR_NEG_LSB    = 0;
    localparam int unsigned ACIR_POS_LSB    = 5;
    localparam int unsigned ACIR_RSV_LSB    = 10;
    localparam int unsigned ACIR_SETUP_LSB  = 12;
    localparam int unsigned ACIR_ACTIVE_BIT = 15;

    // Reset values and write mask
    localparam logic [4:0]  ACIR_NEG_RESET  = 5'h01;
    localparam logic [4:0]  ACIR_POS_RESET  = 5'h00;
    localparam logic [15:0] ACIR_WORD_RESET = {1'b0, 3'h0, 2'h0, ACIR_POS_RESET, ACIR_NEG_RESET};
    localparam logic [15:0] ACIR_WRITE_MASK = 16'hF3FF;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ACIR_IDX_SLOT_00   = 8'h10;
    localparam logic [7:0] ACIR_IDX_SLOT_01   = 8'h11;
    localparam logic [7:0] ACIR_IDX_SLOT_02   = 8'h12;
    localparam logic [7:0] ACIR_IDX_SLOT_03   = 8'h13;
    localparam logic [7:0] ACIR_IDX_SLOT_04   = 8'h14;
    localparam logic [7:0] ACIR_IDX_SLOT_05   = 8'h15;
    localparam logic [7:0] ACIR_IDX_SLOT_06   = 8'h16;
    localparam logic [7:0] ACIR_IDX_SLOT_07   = 8'h17;
    localparam logic [7:0] ACIR_IDX_SLOT_08   = 8'h18;
    localparam logic [7:0] ACIR_IDX_SLOT_09   = 8'h19;
    localparam logic [7:0] ACIR_IDX_SLOT_10   = 8'h1A;
    localparam logic [7:0] ACIR_IDX_SLOT_11   = 8'h1B;
    localparam logic [7:0] ACIR_IDX_SLOT_12   = 8'h1C;
    localparam logic [7:0] ACIR_IDX_SLOT_13   = 8'h1D;
    localparam logic [7:0] ACIR_IDX_SLOT_14   = 8'h1E;
    localparam logic [7:0] ACIR_IDX_SLOT_15   = 8'h1F;
    localparam logic [7:0] ACIR_IDX_STAT_USE  = 8'h30;
    localparam logic [7:0] ACIR_IDX_STAT_SRC  = 8'h31;
    localparam logic [7:0] ACIR_IDX_STAT_CNT  = 8'h32;

    // Selector codes
    localparam logic [4:0] ACIR_CODE_EXT_LAST = 5'h10;
    localparam logic [4:0] ACIR_CODE_TEMP_POS = 5'h11;
    localparam logic [4:0] ACIR_CODE_TEMP_NEG = 5'h12;
    localparam logic [4:0] ACIR_CODE_SUP_POS  = 5'h13;
    localparam logic [4:0] ACIR_CODE_SUP_NEG  = 5'h14;
    localparam logic [4:0] ACIR_CODE_REF_POS  = 5'h15;
    localparam logic [4:0] ACIR_CODE_REF_NEG  = 5'h16;

    typedef enum logic [2:0] {
        ACIR_SRC_EXT,
        ACIR_SRC_TEMP_POS,
        ACIR_SRC_TEMP_NEG,
        ACIR_SRC_SUP_POS,
        ACIR_SRC_SUP_NEG,
        ACIR_SRC_REF_POS,
        ACIR_SRC_REF_NEG,
        ACIR_SRC_BAD
    } acir_src_e;

    typedef enum logic [1:0] {
        ACIR_ST_IDLE,
        ACIR_ST_ANSWER
    } acir_apb_e;

endpackage : acir_pkg

// ### acir_word_store.sv
// Channel word memory with registered read port
`timescale 1ns/1ns
module acir_word_store
    import acir_pkg::*;
#(
    parameter int unsigned           DEPTH = 16,
    parameter int unsigned           AW    = 4,
    parameter logic [15:0]           INIT  = 16'h0001
) (
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                srst_in,
    // Write port
    input  wire logic                wr_en_in,
    input  wire logic [AW-1:0]       wr_addr_in,
    input  wire logic [15:0]         wr_data_in,
    input  wire logic [1:0]          wr_lane_in,
    // Read port
    input  wire logic [AW-1:0]       rd_addr_in,
    output logic      [15:0]         rd_data_out,
    // All words in parallel
    output logic      [DEPTH*16-1:0] words_out
);

    typedef struct packed {
        logic [DEPTH-1:0][15:0] mem;
        logic [15:0]            rd;
    } acir_store_s;

    acir_store_s cur;
    acir_store_s next_cur;

    always_comb begin
        next_cur    = cur;
        next_cur.rd = cur.mem[rd_addr_in];
        if (wr_en_in) begin
            if (wr_lane_in[0]) begin
                next_cur.mem[wr_addr_in][7:0] = wr_data_in[7:0];
            end
            if (wr_lane_in[1]) begin
                next_cur.mem[wr_addr_in][15:8] = wr_data_in[15:8];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cur.mem <= {DEPTH{INIT}};
            cur.rd  <= 16'h0000;
        end else begin
            cur <= next_cur;
        end
    end

    assign rd_data_out = cur.rd;
    assign words_out   = cur.mem;

endmodule : acir_word_store

// ### acir_sel_decode.sv
// Decodes one five-bit input selector code into its source kind
`timescale 1ns/1ns
module acir_sel_decode
    import acir_pkg::*;
(
    // Selector code
    input  wire logic [4:0] code_in,
    // Decoded source
    output acir_src_e       kind_out,
    output logic            legal_out
);

    always_comb begin
        if (code_in <= ACIR_CODE_EXT_LAST) begin
            kind_out = ACIR_SRC_EXT;
        end else if (code_in == ACIR_CODE_TEMP_POS) begin
            kind_out = ACIR_SRC_TEMP_POS;
        end else if (code_in == ACIR_CODE_TEMP_NEG) begin
            kind_out = ACIR_SRC_TEMP_NEG;
        end else if (code_in == ACIR_CODE_SUP_POS) begin
            kind_out = ACIR_SRC_SUP_POS;
        end else if (code_in == ACIR_CODE_SUP_NEG) begin
            kind_out = ACIR_SRC_SUP_NEG;
        end else if (code_in == ACIR_CODE_REF_POS) begin
            kind_out = ACIR_SRC_REF_POS;
        end else if (code_in == ACIR_CODE_REF_NEG) begin
            kind_out = ACIR_SRC_REF_NEG;
        end else begin
            kind_out = ACIR_SRC_BAD;
        end
        legal_out = (kind_out != ACIR_SRC_BAD);
    end

endmodule : acir_sel_decode

// ### acir_route_regs.sv
// APB register bank of per-channel input routing words
`timescale 1ns/1ns
//
// Function
// - Bits 4:0 negative selector, reset one
// - Codes map inputs, temperature, supply, reference
// - Sixteen words at 0x10-0x1F, reset 0x0001
// - All words share one field layout
// - Bits 9:5 positive selector, reset zero
// - Bits 11:10 reserved, read zero
module acir_route_regs
    import acir_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                             clk_in,
    input  wire logic                             srst_in,
    // APB slave
    input  wire logic [ADDR_W-1:0]                paddr_in,
    input  wire logic                             psel_in,
    input  wire logic                             penable_in,
    input  wire logic                             pwrite_in,
    input  wire logic [31:0]                      pwdata_in,
    input  wire logic [3:0]                       pstrb_in,
    output logic      [31:0]                      prdata_out,
    output logic                                  pready_out,
    output logic                                  pslverr_out,
    // Routing per channel
    output logic      [ACIR_CHANNELS-1:0]         channel_active_flag_out,
    output logic      [ACIR_CHANNELS*3-1:0]       setup_select_out,
    output logic      [ACIR_CHANNELS*5-1:0]       positive_input_select_out,
    output logic      [ACIR_CHANNELS*5-1:0]       negative_input_select_out,
    // Source kinds and code faults per channel, and the count of active channels
    output logic      [ACIR_CHANNELS-1:0]         temp_sensor_used_out,
    output logic      [ACIR_CHANNELS-1:0]         supply_span_used_out,
    output logic      [ACIR_CHANNELS-1:0]         reference_used_out,
    output logic      [ACIR_CHANNELS-1:0]         code_fault_out,
    output logic      [ACIR_COUNT_W-1:0]          active_count_out
);

    typedef struct packed {
        acir_apb_e                           st;
        logic [31:0]                         prdata;
        logic                                pslverr;
        logic [ACIR_CHANNELS-1:0]            active;
        logic [ACIR_CHANNELS-1:0][2:0]       setup;
        logic [ACIR_CHANNELS-1:0][4:0]       pos;
        logic [ACIR_CHANNELS-1:0][4:0]       neg;
        logic [ACIR_CHANNELS-1:0]            temp;
        logic [ACIR_CHANNELS-1:0]            supply;
        logic [ACIR_CHANNELS-1:0]            refer;
        logic [ACIR_CHANNELS-1:0]            fault;
        logic [ACIR_COUNT_W-1:0]             count;
    } acir_state_s;

    acir_state_s                          cur;
    acir_state_s                          next_cur;

    logic [ACIR_CHANNELS*16-1:0]          words;
    logic [15:0]                          store_rd;
    logic                                 store_we;
    logic [15:0]                          store_wdata;
    logic [7:0]                           word_idx;
    logic                                 slot_hit;
    logic                                 stat_use_hit;
    logic                                 stat_src_hit;
    logic                                 stat_cnt_hit;
    logic                                 mapped;
    logic                                 access;

    acir_src_e                            pos_kind [ACIR_CHANNELS];
    acir_src_e                            neg_kind [ACIR_CHANNELS];
    logic [ACIR_CHANNELS-1:0]             pos_legal;
    logic [ACIR_CHANNELS-1:0]             neg_legal;

    // Address decode on word index
    always_comb begin
        word_idx = 8'h00;
        if (ADDR_W >= 10) begin
            word_idx = ((paddr_in >> 10) != '0) ? 8'hFF : 8'(paddr_in[ADDR_W-1:2]);
        end
    end

    assign slot_hit     = (word_idx >= ACIR_IDX_SLOT_00) && (word_idx <= ACIR_IDX_SLOT_15);
    assign stat_use_hit = (word_idx == ACIR_IDX_STAT_USE);
    assign stat_src_hit = (word_idx == ACIR_IDX_STAT_SRC);
    assign stat_cnt_hit = (word_idx == ACIR_IDX_STAT_CNT);
    assign mapped       = slot_hit || stat_use_hit || stat_src_hit || stat_cnt_hit;
    assign access       = psel_in && penable_in;

    // Write data with reserved bits forced to zero
    assign store_wdata = pwdata_in[15:0] & ACIR_WRITE_MASK;
    assign store_we    = access && pwrite_in && (cur.st == ACIR_ST_ANSWER) && slot_hit;

    acir_word_store #(
        .DEPTH       (ACIR_CHANNELS),
        .AW          (ACIR_SLOT_W),
        .INIT        (ACIR_WORD_RESET)
    ) u_store (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .wr_en_in    (store_we),
        .wr_addr_in  (word_idx[3:0]),
        .wr_data_in  (store_wdata),
        .wr_lane_in  (pstrb_in[1:0]),
        .rd_addr_in  (word_idx[3:0]),
        .rd_data_out (store_rd),
        .words_out   (words)
    );

    // One decoder pair per channel word
    genvar g;
    generate
        for (g = 0; g < ACIR_CHANNELS; g++) begin : g_chan
            acir_sel_decode u_pos (
                .code_in   (words[g*16+ACIR_POS_LSB +: ACIR_SEL_W]),
                .kind_out  (pos_kind[g]),
                .legal_out (pos_legal[g])
            );
            acir_sel_decode u_neg (
                .code_in   (words[g*16+ACIR_NEG_LSB +: ACIR_SEL_W]),
                .kind_out  (neg_kind[g]),
                .legal_out (neg_legal[g])
            );
        end
    endgenerate

    // Next state
    always_comb begin
        logic [ACIR_COUNT_W-1:0] n_active;
        n_active = '0;
        next_cur = cur;

        // Bus handshake: capture in first access cycle, answer in the next
        unique case (cur.st)
            ACIR_ST_IDLE: begin
                if (access) begin
                    next_cur.st      = ACIR_ST_ANSWER;
                    next_cur.pslverr = !mapped || (pwrite_in && !slot_hit);
                    next_cur.prdata  = 32'h0000_0000;
                    if (!pwrite_in) begin
                        if (slot_hit) begin
                            next_cur.prdata = {16'h0000, store_rd & ACIR_WRITE_MASK};
                        end else if (stat_use_hit) begin
                            next_cur.prdata = {cur.supply, cur.active};
                        end else if (stat_src_hit) begin
                            next_cur.prdata = {cur.refer | cur.temp, cur.fault};
                        end else if (stat_cnt_hit) begin
                            next_cur.prdata = {27'h000_0000, cur.count};
                        end
                    end
                end
            end
            ACIR_ST_ANSWER: begin
                next_cur.st = ACIR_ST_IDLE;
            end
        endcase

        // Field split, same layout in every word
        for (int i = 0; i < ACIR_CHANNELS; i++) begin
            next_cur.active[i] = words[i*16+ACIR_ACTIVE_BIT];
            next_cur.setup[i]  = words[i*16+ACIR_SETUP_LSB +: ACIR_SETUP_W];
            next_cur.pos[i]    = words[i*16+ACIR_POS_LSB +: ACIR_SEL_W];
            next_cur.neg[i]    = words[i*16+ACIR_NEG_LSB +: ACIR_SEL_W];
            next_cur.temp[i]   = (pos_kind[i] == ACIR_SRC_TEMP_POS) || (pos_kind[i] == ACIR_SRC_TEMP_NEG)
                               || (neg_kind[i] == ACIR_SRC_TEMP_POS) || (neg_kind[i] == ACIR_SRC_TEMP_NEG);
            next_cur.supply[i] = (pos_kind[i] == ACIR_SRC_SUP_POS) || (pos_kind[i] == ACIR_SRC_SUP_NEG)
                               || (neg_kind[i] == ACIR_SRC_SUP_POS) || (neg_kind[i] == ACIR_SRC_SUP_NEG);
            next_cur.refer[i]  = (pos_kind[i] == ACIR_SRC_REF_POS) || (pos_kind[i] == ACIR_SRC_REF_NEG)
                               || (neg_kind[i] == ACIR_SRC_REF_POS) || (neg_kind[i] == ACIR_SRC_REF_NEG);
            next_cur.fault[i]  = !pos_legal[i] || !neg_legal[i];
            n_active           = n_active + ACIR_COUNT_W'(words[i*16+ACIR_ACTIVE_BIT]);
        end
        next_cur.count = n_active;
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cur.st      <= ACIR_ST_IDLE;
            cur.prdata  <= 32'h0000_0000;
            cur.pslverr <= 1'b0;
            cur.active  <= '0;
            cur.setup   <= '0;
            cur.pos     <= {ACIR_CHANNELS{ACIR_POS_RESET}};
            cur.neg     <= {ACIR_CHANNELS{ACIR_NEG_RESET}};
            cur.temp    <= '0;
            cur.supply  <= '0;
            cur.refer   <= '0;
            cur.fault   <= '0;
            cur.count   <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    assign pready_out                = (cur.st == ACIR_ST_ANSWER);
    assign prdata_out                = cur.prdata;
    assign pslverr_out               = (cur.st == ACIR_ST_ANSWER) && cur.pslverr;
    assign channel_active_flag_out   = cur.active;
    assign setup_select_out          = cur.setup;
    assign positive_input_select_out = cur.pos;
    assign negative_input_select_out = cur.neg;
    assign temp_sensor_used_out      = cur.temp;
    assign supply_span_used_out      = cur.supply;
    assign reference_used_out        = cur.refer;
    assign code_fault_out            = cur.fault;
    assign active_count_out          = cur.count;

endmodule : acir_route_regs

// ### acir_route_regs_monitor.sv
// Assertion checker for the channel input routing register bank
`timescale 1ns/1ns
module acir_route_regs_monitor
    import acir_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input wire logic              clk_in,
    input wire logic              srst_in,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [31:0]       pwdata_in,
    input wire logic [3:0]        pstrb_in,
    input wire logic [31:0]       prdata_out,
    input wire logic              pready_out,
    input wire logic              pslverr_out,
    // Routing and flags
    input wire logic [15:0]       channel_active_flag_out,
    input wire logic [47:0]       setup_select_out,
    input wire logic [79:0]       positive_input_select_out,
    input wire logic [79:0]       negative_input_select_out,
    input wire logic [15:0]       temp_sensor_used_out,
    input wire logic [15:0]       supply_span_used_out,
    input wire logic [15:0]       reference_used_out,
    input wire logic [15:0]       code_fault_out,
    input wire logic [4:0]        active_count_out
);
    logic [ADDR_W-3:0] idx;
    logic              slot, stat, wr_hit, acc;
    logic [3:0]        wr_ch;
    logic [15:0]       wr_dat, exp_tmp, exp_sup, exp_ref, exp_bad;
    logic [79:0]       pv, nv;
    logic [175:0]      prev_sig;
    logic [1:0]        quiet;
    assign pv = positive_input_select_out;
    assign nv = negative_input_select_out;
    assign idx = paddr_in[ADDR_W-1:2];
    assign slot = idx >= (ADDR_W-2)'(ACIR_IDX_SLOT_00) && idx <= (ADDR_W-2)'(ACIR_IDX_SLOT_15);
    assign stat = idx >= (ADDR_W-2)'(ACIR_IDX_STAT_USE) && idx <= (ADDR_W-2)'(ACIR_IDX_STAT_CNT);
    assign acc = psel_in && penable_in && pready_out;
    assign wr_hit = psel_in && penable_in && pready_out && pwrite_in && slot && pstrb_in[1:0] == 2'b11;
    function automatic logic pair(input logic [4:0] p, input logic [4:0] n, input logic [4:0] a);
        return p == a || p == a + 5'h01 || n == a || n == a + 5'h01;
    endfunction : pair
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            exp_tmp[i] = pair(pv[i*5 +: 5], nv[i*5 +: 5], ACIR_CODE_TEMP_POS);
            exp_sup[i] = pair(pv[i*5 +: 5], nv[i*5 +: 5], ACIR_CODE_SUP_POS);
            exp_ref[i] = pair(pv[i*5 +: 5], nv[i*5 +: 5], ACIR_CODE_REF_POS);
            exp_bad[i] = pv[i*5 +: 5] > ACIR_CODE_REF_NEG || nv[i*5 +: 5] > ACIR_CODE_REF_NEG;
        end
    end
    always_ff @(posedge clk_in) begin
        if (wr_hit) begin
            wr_ch <= idx[3:0];
            wr_dat <= pwdata_in[15:0];
        end
        prev_sig <= {channel_active_flag_out, pv, nv};
        if (srst_in || prev_sig != {channel_active_flag_out, pv, nv}) quiet <= 2'd0;
        else if (quiet != 2'd3) quiet <= quiet + 2'd1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_setup; psel_in && !penable_in; endsequence
    sequence s_access; psel_in && penable_in; endsequence
    chk_one_wait: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
        else $error("ready not in second access cycle");
    chk_neg_lands: assert property (wr_hit |-> ##2 nv[int'(wr_ch)*5 +: 5] == wr_dat[4:0])
        else $error("negative selector did not follow write");
    chk_pos_lands: assert property (wr_hit |-> ##2 pv[int'(wr_ch)*5 +: 5] == wr_dat[9:5])
        else $error("positive selector did not follow write");
    chk_flag_lands: assert property (wr_hit |-> ##2 channel_active_flag_out[wr_ch] == wr_dat[15]
        && setup_select_out[int'(wr_ch)*3 +: 3] == wr_dat[14:12]) else $error("enable or setup wrong");
    chk_reset_neg: assert property ($fell(srst_in) |-> nv == {16{ACIR_NEG_RESET}})
        else $error("negative selector reset value wrong");
    chk_reset_rest: assert property ($fell(srst_in) |-> pv == 80'h0 && channel_active_flag_out == 16'h0
        && setup_select_out == 48'h0 && !pready_out) else $error("reset state wrong");
    chk_rsv_zero: assert property (acc && slot && !pwrite_in |-> prdata_out[11:10] == 2'b00
        && prdata_out[31:16] == 16'h0) else $error("reserved read bits not zero");
    chk_unmapped_err: assert property (acc && !slot && !(stat && !pwrite_in)
        |-> pslverr_out && (pwrite_in || prdata_out == 32'h0)) else $error("unmapped access not refused");
    chk_slot_ok: assert property (acc && slot |-> !pslverr_out)
        else $error("slot access refused");
    chk_decode_flags: assert property (quiet >= 2'd2 |-> temp_sensor_used_out == exp_tmp
        && supply_span_used_out == exp_sup && reference_used_out == exp_ref && code_fault_out == exp_bad)
        else $error("source flags disagree with selectors");
    chk_count_match: assert property (quiet >= 2'd2 |-> active_count_out == 5'($countones(channel_active_flag_out)))
        else $error("active count wrong");
endmodule : acir_route_regs_monitor
bind acir_route_regs acir_route_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_in(clk_in), .srst_in(srst_in),
    .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .channel_active_flag_out(channel_active_flag_out),
    .setup_select_out(setup_select_out), .positive_input_select_out(positive_input_select_out),
    .negative_input_select_out(negative_input_select_out), .temp_sensor_used_out(temp_sensor_used_out),
    .supply_span_used_out(supply_span_used_out), .reference_used_out(reference_used_out),
    .code_fault_out(code_fault_out), .active_count_out(active_count_out));

// ### acir_host_model.sv
// Host model issuing register transfers over APB
`timescale 1ns/1ns
module acir_host_model #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock
    input  wire logic              clk_in,
    // APB master
    output logic      [ADDR_W-1:0] paddr_out,
    output logic                   psel_out,
    output logic                   penable_out,
    output logic                   pwrite_out,
    output logic      [31:0]       pwdata_out,
    output logic      [3:0]        pstrb_out,
    input  wire logic [31:0]       prdata_in,
    input  wire logic              pready_in,
    input  wire logic              pslverr_in
);
    initial begin
        paddr_out = '0;
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        pwdata_out = 32'h0000_0000;
        pstrb_out = 4'h0;
    end
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd, input logic [3:0] st,
                        output logic [31:0] rd, output logic err, output logic ok);
        ok = 1'b0;
        rd = 32'h0000_0000;
        err = 1'b0;
        @(posedge clk_in);
        paddr_out <= ADDR_W'({idx, 2'b00});
        pwrite_out <= wr;
        pwdata_out <= wd;
        pstrb_out <= st;
        psel_out <= 1'b1;
        @(posedge clk_in);
        penable_out <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_in);
            if (pready_in === 1'b1) begin
                ok = 1'b1;
                rd = prdata_in;
                err = pslverr_in;
            end
        end
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~paddr_out;
        pwdata_out <= ~pwdata_out;
    endtask : xfer
endmodule : acir_host_model

// ### acir_route_regs_bench.sv
// Self-checking bench for the channel input routing register bank
`timescale 1ns/1ns
module acir_route_regs_bench
    import acir_pkg::*;
();
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [15:0] act, temp, sup, refu, fault;
    logic [47:0] setup;
    logic [79:0] pos, neg;
    logic [4:0]  cnt;
    int          err_total = 0;
    int          n_checks = 0;
    always #5 clk_in = ~clk_in;
    acir_route_regs #(.ADDR_W(12)) uut (.clk_in(clk_in), .srst_in(srst_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .channel_active_flag_out(act), .setup_select_out(setup),
        .positive_input_select_out(pos), .negative_input_select_out(neg), .temp_sensor_used_out(temp),
        .supply_span_used_out(sup), .reference_used_out(refu), .code_fault_out(fault), .active_count_out(cnt));
    acir_host_model #(.ADDR_W(12)) host (.clk_in(clk_in), .paddr_out(paddr), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .pwdata_out(pwdata), .pstrb_out(pstrb),
        .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic err);
        logic ok;
        host.xfer(idx, wr, wd, st, rd, err, ok);
        if (ok !== 1'b1) begin
            $display("Error transfer completion expected 1 seen 0");
            err_total++;
            close_out();
        end
    endtask : apb
    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 16; i++) begin
            apb(ACIR_IDX_SLOT_00 + 8'(i), 1'b0, 32'h0000_0000, 4'h0, rd, err);
            check("reset word", 32'h0000_0001, rd);
            check("reset negative select", 32'h0000_0001, 32'(neg[i*5 +: 5]));
        end
        $display("reset test done");
    endtask : t_reset
    task automatic t_fields();
        logic [31:0] rd;
        logic        err;
        logic [15:0] w;
        for (int i = 0; i < 16; i++) begin
            w = {1'(i), 3'(i), 2'b11, 5'(i + 7), 5'(i)};
            apb(ACIR_IDX_SLOT_00 + 8'(i), 1'b1, {16'hA5A5, w}, 4'h3, rd, err);
        end
        for (int i = 0; i < 16; i++) begin
            w = {1'(i), 3'(i), 2'b00, 5'(i + 7), 5'(i)};
            apb(ACIR_IDX_SLOT_00 + 8'(i), 1'b0, 32'h0000_0000, 4'h0, rd, err);
            check("slot word", {16'h0000, w}, rd);
            check("positive select", 32'(i + 7), 32'(pos[i*5 +: 5]));
            check("negative select", 32'(i), 32'(neg[i*5 +: 5]));
            check("enable and setup", 32'(w[15:12]), {28'h000_0000, act[i], setup[i*3 +: 3]});
        end
        check("temperature flags", 32'h0000_0C00, 32'(temp));
        check("supply flags", 32'h0000_3000, 32'(sup));
        check("reference flags", 32'h0000_C000, 32'(refu));
        check("active count", 32'h0000_0008, 32'(cnt));
        apb(ACIR_IDX_STAT_USE, 1'b0, 32'h0, 4'h0, rd, err);
        check("use status", 32'h3000_AAAA, rd);
        apb(ACIR_IDX_STAT_SRC, 1'b0, 32'h0, 4'h0, rd, err);
        check("source status", 32'hCC00_0000, rd);
        apb(ACIR_IDX_STAT_CNT, 1'b0, 32'h0, 4'h0, rd, err);
        check("count status", 32'h0000_0008, rd);
        $display("field test done");
    endtask : t_fields
    task automatic t_strobe();
        logic [31:0] rd;
        logic        err;
        logic [15:0] w;
        w = {1'b1, 3'd3, 2'b00, 5'd10, 5'd3};
        apb(ACIR_IDX_SLOT_03, 1'b1, 32'h0000_1234, 4'h1, rd, err);
        apb(ACIR_IDX_SLOT_03, 1'b0, 32'h0000_0000, 4'h0, rd, err);
        check("low lane write", {16'h0000, w[15:8], 8'h34}, rd);
        $display("strobe test done");
    endtask : t_strobe
    task automatic t_errors();
        logic [31:0] rd;
        logic        err;
        logic [7:0]  bad [3] = '{8'h0F, 8'h20, 8'h33};
        foreach (bad[k]) begin
            apb(bad[k], 1'b0, 32'h0000_0000, 4'h0, rd, err);
            check("unmapped error", 32'h0000_0001, 32'(err));
            check("unmapped data", 32'h0000_0000, rd);
        end
        apb(ACIR_IDX_STAT_USE, 1'b1, 32'hFFFF_FFFF, 4'hF, rd, err);
        check("status write error", 32'h0000_0001, 32'(err));
        apb(ACIR_IDX_SLOT_05, 1'b1, 32'h0000_001F, 4'h3, rd, err);
        apb(ACIR_IDX_SLOT_05, 1'b0, 32'h0000_0000, 4'h0, rd, err);
        check("illegal code stored", 32'h0000_001F, rd);
        check("code fault flag", 32'h0000_0001, 32'(fault[5]));
        $display("error test done");
    endtask : t_errors
    task automatic t_rereset();
        logic [31:0] rd;
        logic        err;
        apb(ACIR_IDX_SLOT_00, 1'b1, 32'h0000_8000, 4'h3, rd, err);
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        apb(ACIR_IDX_SLOT_00, 1'b0, 32'h0000_0000, 4'h0, rd, err);
        check("word after reset", 32'h0000_0001, rd);
        check("count after reset", 32'h0000_0000, 32'(cnt));
        $display("second reset test done");
    endtask : t_rereset
    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_fields();
        t_strobe();
        t_errors();
        t_rereset();
        close_out();
    end
endmodule : acir_route_regs_bench
